// ===== hw/rcpnl_pkg.sv
/*
 * package for the recloser operator panel control: register map,
 * field positions, reset values and timing constants.
 * assumes a 100 MHz system clock and a 32-bit apb register bus.
 */
package rcpnl_pkg;
	// register byte offsets
	localparam logic [11:0] RCPNL_OFS_CTRL   = 12'h000; // remote function control
	localparam logic [11:0] RCPNL_OFS_STATUS = 12'h004; // live state readback
	localparam logic [11:0] RCPNL_OFS_OPTMAP = 12'h008; // option key assignment
	localparam logic [11:0] RCPNL_OFS_CMD    = 12'h00C; // remote pulse commands
	// ctrl fields
	localparam int RCPNL_C_TAG    = 0;  // serial live-line tag request
	localparam int RCPNL_C_GTI    = 1;  // remote ground trip inhibit
	localparam int RCPNL_C_NRC    = 2;  // remote non-reclosing
	localparam int RCPNL_C_CLPEN  = 3;  // cold load pickup enabled
	localparam int RCPNL_C_PROF   = 4;  // profile, 2 bits
	localparam int RCPNL_C_PROFWR = 6;  // write strobe for profile field
	// cmd fields
	localparam int RCPNL_K_TRIP   = 0;  // remote trip
	localparam int RCPNL_K_CLOSE  = 1;  // remote close
	// option functions, 4 bit codes, 0 is unassigned
	localparam logic [3:0] RCPNL_OPT_NONE = 4'h0;
	localparam logic [3:0] RCPNL_OPT_CLPB = 4'h2; // cold load pickup blocked
	localparam logic [3:0] RCPNL_OPT_FTB  = 4'h4; // fast trip blocked
	localparam logic [3:0] RCPNL_OPT_MAX  = 4'h9; // highest code
	localparam logic [31:0] RCPNL_RST_WORD = 32'h0000_0000;
	// timing
	localparam int RCPNL_CLK_MHZ      = 100;
	localparam int RCPNL_CHG_S        = 10; // change window, seconds
	localparam int RCPNL_CFAIL_S      = 5;  // close failure alarm, seconds
	localparam int RCPNL_DEB_MS       = 10; // debounce, milliseconds
	localparam int RCPNL_CHG_CYC      = RCPNL_CHG_S * RCPNL_CLK_MHZ * 1_000_000;
	localparam int RCPNL_CFAIL_CYC    = RCPNL_CFAIL_S * RCPNL_CLK_MHZ * 1_000_000;
	localparam int RCPNL_DEB_CYC      = RCPNL_DEB_MS * RCPNL_CLK_MHZ * 1_000;
	// close sequencing states
	typedef enum logic [2:0] {
		RCPNL_CS_IDLE = 3'b001,
		RCPNL_CS_PEND = 3'b010,
		RCPNL_CS_FAIL = 3'b100
	} rcpnl_cls_t;
endpackage : rcpnl_pkg

// ===== hw/rcpnl_top.sv
/*
 * recloser operator panel control: tag interlock, close supervision,
 * trip and close buttons, change mode and function keys, apb registers.
 * assumes panel keys are raw asynchronous levels, active high when
 * pressed, and the protection engine consumes the mode outputs.
 */
`timescale 1ns/100ps
`default_nettype none
module rcpnl_top #(
	parameter int CHG_CYC   = rcpnl_pkg::RCPNL_CHG_CYC,   // change window length
	parameter int CFAIL_CYC = rcpnl_pkg::RCPNL_CFAIL_CYC, // close failure delay
	parameter int DEB_CYC   = rcpnl_pkg::RCPNL_DEB_CYC,   // debounce length
	parameter int NKEY      = 13                          // panel key count
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic [NKEY-1:0] key_in,        // raw panel keys
	input  wire logic        scada_tag_in,      // discrete tag request
	input  wire logic        scada_gti_in,      // discrete ground trip inhibit
	input  wire logic        scada_nrc_in,      // discrete non-reclosing
	input  wire logic        scada_trip_in,     // discrete supervisory trip pulse level
	input  wire logic        scada_close_in,    // discrete supervisory close level
	input  wire logic        fuse_in,           // close fuse present
	input  wire logic        closed_in,         // recloser closed contact
	input  wire logic        auto_close_in,     // reclose request from protection
	output logic             trip_out,          // trip coil drive
	output logic             close_out,         // close coil drive
	output logic             lockout_out,       // control locked out
	output logic             seq_reset_out,     // sequence back to first step
	output logic             tag_out,           // live-line tag active / led
	output logic             one_shot_out,      // single trip to lockout
	output logic             fast_curve_out,    // time on faster of tag delay, first curve
	output logic             clp_out,           // cold load pickup active
	output logic             nrc_out,           // non-reclosing effective
	output logic             ftb_out,           // fast trips disabled effective
	output logic             gti_out,           // ground trip inhibit / led
	output logic             sup_blk_out,       // supervisory block / led
	output logic [1:0]       profile_out,       // active profile, 0 normal
	output logic [2:0]       prof_led_out,      // alternate profile leds
	output logic [2:0]       opt_led_out,       // option key leds
	output logic             cfail_out,         // close failure alarm
	output logic             chg_out            // change mode led
);
	import rcpnl_pkg::*;

	// key indexes
	localparam int K_TRIP = 0, K_CLOSE = 1, K_TAG = 2, K_CHG = 3, K_GTI = 4;
	localparam int K_NRC = 5, K_SUP = 6, K_PR1 = 7, K_OP1 = 10;

	logic [NKEY-1:0] s1, s2;          // synchroniser stages
	logic [NKEY-1:0] deb;             // debounced level
	logic [NKEY-1:0] deb_q;           // previous debounced level
	logic [NKEY-1:0] press;           // one-cycle press events
	logic [31:0]     deb_cnt [NKEY];  // per key stability counters
	logic [6:0]      d1, d2;          // discrete input synchronisers
	logic            fuse_ok;         // synchronised fuse present
	logic            closed_s;        // synchronised closed contact
	// fuse and contact are pins too; only the second flop is read
	assign fuse_ok = d2[5];
	assign closed_s = d2[6];

	// two-flop synchroniser; s1 feeds only s2
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s1 <= '0;
			s2 <= '0;
			d1 <= '0;
			d2 <= '0;
		end else begin
			s1 <= key_in;
			s2 <= s1;
			d1 <= {closed_in, fuse_in, scada_close_in, scada_trip_in, scada_nrc_in,
			       scada_gti_in, scada_tag_in};
			d2 <= d1;
		end
	end

	// debounce: level accepted after DEB_CYC stable cycles
	// bounces shorter than that are lost, which is the point
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			deb <= '0;
			deb_q <= '0;
			for (int i = 0; i < NKEY; i++) deb_cnt[i] <= '0;
		end else begin
			deb_q <= deb;
			for (int i = 0; i < NKEY; i++) begin
				if (s2[i] == deb[i]) begin
					deb_cnt[i] <= '0;
				end else if (deb_cnt[i] >= 32'(DEB_CYC - 1)) begin
					deb[i] <= s2[i];
					deb_cnt[i] <= '0;
				end else begin
					deb_cnt[i] <= deb_cnt[i] + 32'd1;
				end
			end
		end
	end
	assign press = deb & ~deb_q;

	// apb register state
	logic [31:0] ctrl;        // remote control word
	logic [11:0] optmap;      // three 4-bit option assignments
	logic        rtrip_p;     // remote trip pulse
	logic        rclose_p;    // remote close pulse
	logic        rprof_p;     // remote profile write pulse
	logic [1:0]  rprof_v;     // remote profile value
	logic        wr_en;       // write access edge
	logic        rear_ok;     // rear commands allowed
	assign wr_en = psel_in & penable_in & pwrite_in;
	assign pready_out = 1'b1;
	assign rear_ok = ~sup_blk_out;

	// register writes; rear port commands other than tag and option map writes dropped under supervisory block
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl <= RCPNL_RST_WORD;
			optmap <= '0;
			rtrip_p <= 1'b0;
			rclose_p <= 1'b0;
			rprof_p <= 1'b0;
			rprof_v <= '0;
		end else begin
			rtrip_p <= 1'b0;
			rclose_p <= 1'b0;
			rprof_p <= 1'b0;
			if (wr_en && pstrb_in[0]) begin
				if (paddr_in == RCPNL_OFS_CTRL) begin
					// tag request is serial-owned, never from another source
					ctrl[RCPNL_C_TAG] <= pwdata_in[RCPNL_C_TAG];
					if (rear_ok) begin
						ctrl[RCPNL_C_GTI] <= pwdata_in[RCPNL_C_GTI];
						ctrl[RCPNL_C_NRC] <= pwdata_in[RCPNL_C_NRC];
						ctrl[RCPNL_C_CLPEN] <= pwdata_in[RCPNL_C_CLPEN];
						rprof_p <= pwdata_in[RCPNL_C_PROFWR];
						rprof_v <= pwdata_in[RCPNL_C_PROF +: 2];
					end
				end else if (paddr_in == RCPNL_OFS_OPTMAP) begin
					optmap[7:0] <= pwdata_in[7:0];
				end else if (paddr_in == RCPNL_OFS_CMD && rear_ok) begin
					rtrip_p <= pwdata_in[RCPNL_K_TRIP];
					rclose_p <= pwdata_in[RCPNL_K_CLOSE];
				end
			end
			if (wr_en && pstrb_in[1] && paddr_in == RCPNL_OFS_OPTMAP) begin
				optmap[11:8] <= pwdata_in[11:8];
			end
		end
	end

	// change mode and panel function state
	logic        chg;          // change mode open
	logic [31:0] chg_cnt;      // window counter
	logic        p_tag;        // panel tag request
	logic        p_gti;        // panel ground trip inhibit
	logic        p_nrc;        // panel non-reclosing
	logic        sup;          // supervisory block
	logic [1:0]  prof;         // active profile
	logic [2:0]  opt_on;       // option key states
	logic        fn_key;       // any function key press
	assign fn_key = |press[NKEY-1:K_GTI];

	// change window; one selection closes it, timeout changes nothing
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			chg <= 1'b0;
			chg_cnt <= '0;
		end else if (press[K_CHG]) begin
			chg <= 1'b1;
			chg_cnt <= '0;
		end else if (chg && (fn_key || chg_cnt >= 32'(CHG_CYC - 1))) begin
			chg <= 1'b0;
			chg_cnt <= '0;
		end else if (chg) begin
			chg_cnt <= chg_cnt + 32'd1;
		end
	end

	// panel toggles other than tag, only taken in change mode; profile may also be set remotely outside change mode
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			p_tag <= 1'b0;
			p_gti <= 1'b0;
			p_nrc <= 1'b0;
			sup <= 1'b0;
			prof <= '0;
			opt_on <= '0;
		end else begin
			if (press[K_TAG]) p_tag <= ~p_tag;
			if (chg) begin
				if (press[K_GTI]) p_gti <= ~p_gti;
				if (press[K_NRC]) p_nrc <= ~p_nrc;
				if (press[K_SUP]) sup <= ~sup;
				for (int i = 0; i < 3; i++) begin
					if (press[K_PR1+i]) begin
						// active key deselects, other key selects
						prof <= (prof == 2'(i + 1)) ? 2'd0 : 2'(i + 1);
					end
					if (press[K_OP1+i] && optmap[4*i +: 4] != RCPNL_OPT_NONE &&
					    optmap[4*i +: 4] <= RCPNL_OPT_MAX) begin
						opt_on[i] <= ~opt_on[i];
					end
				end
			end else if (rprof_p) begin
				prof <= rprof_v;
			end
		end
	end

	// option function decode
	logic clpb;   // cold load pickup blocked
	logic ftb_o;  // fast trip blocked
	always_comb begin
		clpb = 1'b0;
		ftb_o = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (opt_on[i] && optmap[4*i +: 4] == RCPNL_OPT_CLPB) clpb = 1'b1;
			if (opt_on[i] && optmap[4*i +: 4] == RCPNL_OPT_FTB) ftb_o = 1'b1;
		end
	end

	// tag and mode resolution
	logic tag;    // combined tag
	logic gti_a;  // combined ground trip inhibit
	logic nrc_a;  // combined non-reclosing
	assign tag = p_tag | ctrl[RCPNL_C_TAG] | d2[0];
	assign gti_a = p_gti | ctrl[RCPNL_C_GTI] | (d2[1] & rear_ok);
	assign nrc_a = p_nrc | ctrl[RCPNL_C_NRC] | (d2[2] & rear_ok);

	// close and trip sources
	logic trip_req;   // any trip request
	logic close_req;  // any close request
	logic man_close;  // manual or remote close
	logic lock;       // lockout state
	logic clp;        // cold load pickup active
	rcpnl_cls_t cs;   // close supervision state
	logic [31:0] cf_cnt; // close failure counter
	logic [1:0]  dtc_q;  // discrete trip/close previous
	assign trip_req = press[K_TRIP] | rtrip_p | (d2[3] & ~dtc_q[0] & rear_ok);
	assign man_close = press[K_CLOSE] | rclose_p | (d2[4] & ~dtc_q[1] & rear_ok);
	// tag cancels every close source; auto reclose also obeys non-reclosing
	assign close_req = ~tag & (man_close | (auto_close_in & ~nrc_a & ~lock));

	// outputs drawn from mode state; tag wins over cold load and friends
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tag_out <= 1'b0;
			one_shot_out <= 1'b0;
			fast_curve_out <= 1'b0;
			nrc_out <= 1'b0;
			ftb_out <= 1'b0;
			clp_out <= 1'b0;
			gti_out <= 1'b0;
			sup_blk_out <= 1'b0;
			profile_out <= '0;
			prof_led_out <= '0;
			opt_led_out <= '0;
			chg_out <= 1'b0;
			dtc_q <= '0;
		end else begin
			dtc_q <= d2[4:3];
			tag_out <= tag;
			one_shot_out <= tag;
			fast_curve_out <= tag;
			nrc_out <= nrc_a & ~tag;
			ftb_out <= ftb_o & ~tag;
			clp_out <= clp & ~tag;
			gti_out <= gti_a;
			sup_blk_out <= sup;
			profile_out <= prof;
			prof_led_out <= {prof == 2'd3, prof == 2'd2, prof == 2'd1};
			opt_led_out <= opt_on;
			chg_out <= chg;
		end
	end

	// close supervision: pending while fuse out, alarm after delay
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cs <= RCPNL_CS_IDLE;
			cf_cnt <= '0;
			close_out <= 1'b0;
			cfail_out <= 1'b0;
		end else begin
			close_out <= 1'b0;
			case (cs)
				RCPNL_CS_IDLE: begin
					cf_cnt <= '0;
					if (close_req && !trip_req) begin
						if (fuse_ok) close_out <= 1'b1;
						else cs <= RCPNL_CS_PEND;
					end
				end
				RCPNL_CS_PEND: begin
					cf_cnt <= cf_cnt + 32'd1;
					if (tag || trip_req) begin
						cs <= RCPNL_CS_IDLE;
					end else if (fuse_ok) begin
						close_out <= 1'b1;
						cs <= RCPNL_CS_IDLE;
					end else if (cf_cnt >= 32'(CFAIL_CYC - 1)) begin
						cfail_out <= 1'b1;
						cs <= RCPNL_CS_FAIL;
					end
				end
				RCPNL_CS_FAIL: begin
					// alarm stands until a fresh close with fuse back
					if (close_req && fuse_ok && !trip_req) begin
						cfail_out <= 1'b0;
						close_out <= 1'b1;
						cs <= RCPNL_CS_IDLE;
					end
				end
				default: cs <= RCPNL_CS_IDLE;
			endcase
		end
	end

	// trip, lockout, sequence reset and cold load pickup
	// trip_out only from requests; tag never drives it
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			trip_out <= 1'b0;
			lock <= 1'b1;
			seq_reset_out <= 1'b0;
			clp <= 1'b0;
		end else begin
			trip_out <= trip_req;
			seq_reset_out <= 1'b0;
			if (trip_req) begin
				lock <= 1'b1;
			end else if (man_close && !tag) begin
				lock <= 1'b0;
				seq_reset_out <= 1'b1;
				if (lock && !closed_s && ctrl[RCPNL_C_CLPEN] && !clpb) begin
					clp <= 1'b1;
				end
			end
			if (trip_req) clp <= 1'b0;
		end
	end
	assign lockout_out = lock;

	// apb read mux; unmapped reads zero with error
	always_comb begin
		prdata_out = 32'h0000_0000;
		pslverr_out = 1'b0;
		if (paddr_in == RCPNL_OFS_CTRL) begin
			prdata_out = {25'h0, 1'b0, prof, ctrl[3:0]};
		end else if (paddr_in == RCPNL_OFS_STATUS) begin
			prdata_out = {20'h0, chg, cfail_out, clp, lock, sup, gti_a, nrc_a, tag,
			              d2[0], ctrl[RCPNL_C_TAG], p_tag, 1'b0};
		end else if (paddr_in == RCPNL_OFS_OPTMAP) begin
			prdata_out = {20'h0, optmap};
		end else if (paddr_in == RCPNL_OFS_CMD) begin
			prdata_out = 32'h0000_0000;
		end else begin
			pslverr_out = psel_in & penable_in;
		end
	end

	// checks
	a_tag_blocks_close: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		tag_out && tag |-> !close_out) else $error("close issued under tag");
	a_tag_no_trip: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		$rose(tag_out) && !$past(trip_req) |-> !trip_out) else $error("tag tripped");
	a_tag_one_shot: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		tag_out |-> one_shot_out && fast_curve_out) else $error("tag mode wrong");
	a_tag_over_clp: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		tag_out |-> !clp_out && !nrc_out && !ftb_out) else $error("tag lost priority");
	a_tag_or: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		p_tag |=> tag_out) else $error("panel tag ignored");
	a_fuse_close: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		!fuse_ok |=> !close_out) else $error("close without fuse");
	a_trip_lock: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		press[K_TRIP] |=> trip_out && lock) else $error("trip button lost");
	a_chg_one_shot: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		chg && press[K_GTI] && !press[K_CHG] |=> !chg && (p_gti != $past(p_gti)))
		else $error("change mode selection wrong");
	a_no_chg_no_toggle: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		!chg |=> $stable(sup)) else $error("sup changed outside change mode");
	a_one_profile: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		$countones(prof_led_out) <= 1) else $error("several profiles lit");
endmodule : rcpnl_top
`default_nettype wire

// ===== test/rcpnl_panel_model.sv
/* front panel model: turns a press request into a bouncing key contact.
 * assumes the bench asks for one press at a time, on a rising edge. */
`timescale 1ns/100ps
`default_nettype none
module rcpnl_panel_model (
	input  wire logic        clk_in,   // system clock
	input  wire logic        press_in, // start one press
	input  wire logic [3:0]  idx_in,   // key index to press
	output logic      [12:0] key_out   // raw contact levels
);
	int         cnt; // cycles left in the press
	logic [3:0] idx; // key being pressed
	// press timeline: eight cycles of bounce, then a solid hold
	always_ff @(posedge clk_in) begin
		if (press_in) begin
			cnt <= 20;
			idx <= idx_in;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	// bounce is shorter than the debounce window, so it must not count as a press
	always_comb begin
		key_out = 13'h0000;
		if (cnt > 12) begin
			key_out[idx] = cnt[0];
		end else if (cnt > 0) begin
			key_out[idx] = 1'b1;
		end
	end
endmodule : rcpnl_panel_model
`default_nettype wire

// ===== test/testbench.sv
/* self-checking bench: keys through the panel model, apb and discrete
 * inputs, results compared with an integer model of the panel control.
 * assumes the shortened change, close failure and debounce counts below. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import rcpnl_pkg::*;
	localparam int CHG = 50; // shortened change window
	localparam int CFL = 40; // shortened close failure delay
	logic        mclk_in, rst_b_in, psel, penable, pwrite, press, err, sc_tag, sc_gti, sc_trip;
	logic        fuse, closed, auto_cl, pready, pslverr, trip, close, lock, seqr, tag, one, fast;
	logic        clp, nrc, ftb, gti, sup, cfail, chg;
	logic [11:0] paddr, v;
	logic [12:0] key;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pidx, pstrb;
	logic [1:0]  prof;
	logic [2:0]  pled, oled;
	int          mismatches, comparisons, cyc, n_trip, n_close, n_seq;
	int          m_src[3], m_gti, m_sup, m_prof, m_lock, m_trip, m_close; // integer model
	rcpnl_top #(.CHG_CYC(CHG), .CFAIL_CYC(CFL), .DEB_CYC(3)) dut (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .paddr_in(paddr), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(pstrb),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .key_in(key),
		.scada_tag_in(sc_tag), .scada_gti_in(sc_gti), .scada_nrc_in(1'b0),
		.scada_trip_in(sc_trip), .scada_close_in(1'b0), .fuse_in(fuse), .closed_in(closed),
		.auto_close_in(auto_cl), .trip_out(trip), .close_out(close), .lockout_out(lock),
		.seq_reset_out(seqr), .tag_out(tag), .one_shot_out(one), .fast_curve_out(fast),
		.clp_out(clp), .nrc_out(nrc), .ftb_out(ftb), .gti_out(gti), .sup_blk_out(sup),
		.profile_out(prof), .prof_led_out(pled), .opt_led_out(oled), .cfail_out(cfail),
		.chg_out(chg));
	rcpnl_panel_model pm (.clk_in(mclk_in), .press_in(press), .idx_in(pidx), .key_out(key));
	// 100 MHz system clock
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	// pulse counters, since trip and close pulses last one cycle only
	always @(posedge mclk_in) begin
		n_trip += (trip === 1'b1);
		n_close += (close === 1'b1);
		n_seq += (seqr === 1'b1);
		cyc++;
		if (cyc == 20000) begin // hang guard
			mismatches++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic settle(input int n); // let n edges pass, sample mid-cycle
		repeat (n) @(posedge mclk_in);
		@(negedge mclk_in);
	endtask : settle
	// one apb transfer; held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hF;
		@(posedge mclk_in);
		penable <= 1'b1;
		do begin
			@(posedge mclk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// side inputs change only just after a rising edge
	task automatic pin(input int w, input logic b);
		@(posedge mclk_in);
		case (w)
			0: sc_tag <= b;
			1: sc_gti <= b;
			2: sc_trip <= b;
			3: fuse <= b;
			4: closed <= b;
			default: auto_cl <= b;
		endcase
	endtask : pin
	task automatic push(input int k); // one bouncing press of key k
		@(posedge mclk_in);
		press <= 1'b1;
		pidx <= k[3:0];
		@(posedge mclk_in);
		press <= 1'b0;
		settle(26);
	endtask : push
	task automatic state(); // compare the levels and pulse counts with the model
		chk("tag", 32'((m_src[0] | m_src[1] | m_src[2]) != 0), {31'b0, tag});
		chk("gti", m_gti, {31'b0, gti});
		chk("sup", m_sup, {31'b0, sup});
		chk("profile", m_prof, {30'b0, prof});
		chk("prof_led", (m_prof == 0) ? 0 : (1 << (m_prof - 1)), {29'b0, pled});
		chk("lockout", m_lock, {31'b0, lock});
		chk("trips", m_trip, n_trip);
		chk("closes", m_close, n_close);
	endtask : state
	task automatic end_sim();
		$display("errors: %0d mismatches in %0d comparisons", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial begin
		rst_b_in = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
		pwdata = 32'h0000_0000; pstrb = 4'h0; press = 1'b0; pidx = 4'h0; sc_tag = 1'b0;
		sc_gti = 1'b0; sc_trip = 1'b0; fuse = 1'b1; closed = 1'b0; auto_cl = 1'b0;
		m_lock = 1;
		repeat (16) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		v = 12'($urandom(66642));
		settle(2);
		state();
		chk("cfail", 0, {31'b0, cfail});
		// three tag sources, each one cleared only by itself
		push(2); m_src[0] = 1;
		apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_0001); m_src[1] = 1;
		sc_tag <= 1'b1; m_src[2] = 1;
		apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_0000); m_src[1] = 0;
		settle(4);
		state();
		apb(1'b0, RCPNL_OFS_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_001A, rd & 32'h0000_001E);
		apb(1'b1, RCPNL_OFS_CMD, 32'h0000_0002);
		push(1);
		pin(5, 1'b1);
		pin(5, 1'b0);
		settle(4);
		state();
		chk("one_shot", 1, {31'b0, one});
		chk("fast_curve", 1, {31'b0, fast});
		pin(0, 1'b0); m_src[2] = 0;
		push(2); m_src[0] = 0;
		state();
		// close while closed, then cold load blocked, then allowed
		apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_0008);
		closed <= 1'b1;
		push(1); m_close++; m_lock = 0;
		chk("seq_reset", 1, n_seq);
		chk("clp", 0, {31'b0, clp});
		push(0); m_trip++; m_lock = 1;
		state();
		apb(1'b1, RCPNL_OFS_OPTMAP, {20'h0_0000, 8'h00, RCPNL_OPT_CLPB});
		push(3); push(10);
		chk("opt_led", 1, {29'b0, oled});
		pin(4, 1'b0);
		push(1); m_close++; m_lock = 0;
		chk("clp", 0, {31'b0, clp});
		push(0); m_trip++; m_lock = 1;
		push(3); push(10);
		push(1); m_close++; m_lock = 0;
		chk("clp", 1, {31'b0, clp});
		state();
		// non-reclosing holds back the automatic close only
		apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_000C);
		for (int i = 0; i < 2; i++) begin
			settle(2);
			chk("nrc", 32'(1 - i), {31'b0, nrc});
			pin(5, 1'b1);
			pin(5, 1'b0);
			settle(4);
			state();
			apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_0008); m_close += 1 - i;
		end
		// fuse out: trip still works, close waits, then alarms
		fuse <= 1'b0;
		push(0); m_trip++; m_lock = 1;
		push(1); m_lock = 0;
		state();
		pin(3, 1'b1); m_close++;
		settle(5);
		state();
		pin(3, 1'b0);
		push(0); m_trip++; m_lock = 1;
		push(1); m_lock = 0;
		settle(CFL);
		chk("cfail", 1, {31'b0, cfail});
		pin(3, 1'b1);
		settle(5);
		state();
		push(1); m_close++;
		chk("cfail", 0, {31'b0, cfail});
		// change mode: no key without it, one key then out, expiry
		push(4);
		state();
		push(3);
		chk("chg", 1, {31'b0, chg});
		push(4); m_gti = 1;
		chk("chg", 0, {31'b0, chg});
		push(3);
		settle(CHG + 10);
		push(4);
		state();
		push(3); push(4); m_gti = 0;
		pin(1, 1'b1); m_gti = 1;
		settle(4);
		state();
		pin(1, 1'b0); m_gti = 0;
		// profiles: select, switch, deselect back to normal
		push(3); push(7); m_prof = 1; state();
		push(3); push(8); m_prof = 2; state();
		push(3); push(8); m_prof = 0; state();
		// supervisory block: rear requests refused, tag and buttons still served
		push(3); push(6); m_sup = 1;
		apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_0003); m_src[1] = 1;
		apb(1'b1, RCPNL_OFS_CMD, 32'h0000_0001);
		sc_trip <= 1'b1;
		settle(6);
		pin(2, 1'b0);
		settle(6);
		state();
		push(0); m_trip++; m_lock = 1;
		apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_0000); m_src[1] = 0;
		push(3); push(6); m_sup = 0;
		state();
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk("pslverr", 1, {31'b0, err});
		// option three as fast trip blocked, tag wins over it, remote profile
		apb(1'b1, RCPNL_OFS_OPTMAP, 32'h0000_0400);
		push(3); push(12);
		chk("opt_led", 4, {29'b0, oled});
		chk("ftb", 1, {31'b0, ftb});
		apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_0061); m_src[1] = 1; m_prof = 2;
		settle(2);
		chk("ftb", 0, {31'b0, ftb});
		state();
		apb(1'b1, RCPNL_OFS_CTRL, 32'h0000_0000); m_src[1] = 0;
		// random legal option codes read back whole
		for (int i = 0; i < 4; i++) begin
			v = {4'($urandom_range(9, 1)), 4'($urandom_range(9, 1)), 4'($urandom_range(9, 1))};
			apb(1'b1, RCPNL_OFS_OPTMAP, {20'h0_0000, v});
			apb(1'b0, RCPNL_OFS_OPTMAP, 32'h0000_0000);
			chk("optmap", {20'h0_0000, v}, rd & 32'h0000_0FFF);
		end
		end_sim();
	end
endmodule : testbench
`default_nettype wire
